// [rsc_pkg.sv]
// package: register map, field positions and shared types for the random/supply block
`default_nettype none
package rsc_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] RANDOM_VALUE_ADDR = 16'h6105;
  localparam logic [15:0] RNG_SUPPLY_CONTROL_ADDR = 16'h6106;
  // ==========================================================
  // control register fields
  localparam int CTL_RSVD0_BIT = 0;
  localparam int CTL_VALID_BIT = 1;
  localparam int CTL_FORCE_BIT = 2;
  localparam int CTL_RSVD3_BIT = 3;
  localparam int CTL_SUPPLY_EN_BIT = 4;
  localparam int CTL_OVERLOAD_BIT = 5;
  localparam int CTL_MASK_BIT = 6;
  localparam int CTL_RSVD7_BIT = 7;
  localparam logic RSVD0_VALUE = 1'b1;
  localparam logic RSVD3_VALUE = 1'b0;
  localparam logic RSVD7_VALUE = 1'b0;
  localparam logic MASK_RESET = 1'b1;
  localparam logic SUPPLY_EN_RESET = 1'b0;
  localparam logic FORCE_RESET = 1'b0;
  localparam logic [7:0] RANDOM_RESET = 8'h00;
  // ==========================================================
  // generator
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ==========================================================
  // clock source for the secure link
  localparam logic CLK_SRC_OSC = 1'b0;
  localparam logic CLK_SRC_RF = 1'b1;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsc_bus_req_t;
endpackage : rsc_pkg
`default_nettype wire

// [rsc_sync.sv]
// three-stage pad synchroniser with agreement filter
`default_nettype none
module rsc_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pad,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } rsc_sync_st_t;
  rsc_sync_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pad;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= {INIT, INIT, INIT, INIT};
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;
endmodule : rsc_sync
`default_nettype wire

// [rsc_lfsr.sv]
// lfsr that steps only while run is high and assembles one random byte per eight steps
`default_nettype none
module rsc_lfsr (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  output logic [7:0] byte_out,
  output logic byte_done
);
  typedef struct packed {
    logic [15:0] lfsr;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic done;
  } rsc_lfsr_st_t;
  rsc_lfsr_st_t st_q, st_d;
  logic fb;

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    fb = ^(st_q.lfsr & rsc_pkg::LFSR_TAPS);
    if (run) begin
      st_d.lfsr = {st_q.lfsr[14:0], fb};
      st_d.shreg = {st_q.shreg[6:0], fb};
      if (st_q.cnt == rsc_pkg::BITS_PER_BYTE - 4'h1) begin
        st_d.cnt = 4'h0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '{lfsr: rsc_pkg::LFSR_SEED, shreg: 8'h00, cnt: 4'h0, done: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign byte_out = st_q.shreg;
  assign byte_done = st_q.done;
endmodule : rsc_lfsr
`default_nettype wire

// [rsc_top.sv]
// random byte register, secure supply switch control and secure link input gating
//
// Design decision made here: strobed register access.
`default_nettype none
// Behaviour
// - the newest generated byte is readable at the random value register address.
// - the valid flag in bit 1 of the control register is set when a fresh byte lands.
// - a read of the random value register clears the valid flag, unless a new byte lands in the same cycle.
// - with force-run clear, the interface unit's request decides when the generator runs.
// - with force-run set, the generator runs all the time.
// - with the input mask clear, the two secure pads pass straight to internal logic.
// - with the input mask set, internal link input is 0 and internal aux pin is 1.
// - bit 5 reads the live overload state of the supply switch.
// - with supply enable clear, the switch is off and the supply is tied to ground.
// - with supply enable set, the supply powers the secure chip and its pads.
// - with driver mix set, the antenna drivers follow link input and coder together.
// - the link input is sampled fast enough for rates above 424 kbit/s.
module rsc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ciu_rng_request,
  input wire logic secure_link_in_pad,
  input wire logic aux_secure_pin_pad,
  input wire logic overload_pad,
  input wire logic coder_out,
  input wire logic driver_mix_select,
  input wire logic link_clk_source_select,
  input wire logic osc_clk_en,
  input wire logic rf_clk_en,
  output logic secure_link_in_int,
  output logic aux_secure_pin_int,
  output logic supply_switch_en,
  output logic supply_tie_ground,
  output logic antenna_driver_1,
  output logic antenna_driver_2,
  output logic secure_link_clk_en
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] random_value;
    logic valid;
    logic force_run;
    logic supply_en;
    logic mask;
    logic [7:0] rdata;
    logic link_in;
    logic aux_pin;
    logic sw_en;
    logic tie_gnd;
    logic drv1;
    logic drv2;
    logic clk_en;
  } rsc_top_st_t;
  rsc_top_st_t st_q, st_d;

  rsc_pkg::rsc_bus_req_t req;
  logic link_sync;
  logic aux_sync;
  logic ovl_sync;
  logic run;
  logic [7:0] gen_byte;
  logic gen_done;
  logic [7:0] ctl_view;
  logic link_gated;
  logic drive_bit;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ==========================================================
  // pad synchronisers
  rsc_sync #(.INIT(1'b0)) u_sync_link (
    .clk(clk),
    .reset_n(reset_n),
    .pad(secure_link_in_pad),
    .level(link_sync)
  );
  rsc_sync #(.INIT(1'b1)) u_sync_aux (
    .clk(clk),
    .reset_n(reset_n),
    .pad(aux_secure_pin_pad),
    .level(aux_sync)
  );
  rsc_sync #(.INIT(1'b0)) u_sync_ovl (
    .clk(clk),
    .reset_n(reset_n),
    .pad(overload_pad),
    .level(ovl_sync)
  );

  // ==========================================================
  // generator
  assign run = st_q.force_run | ciu_rng_request;

  rsc_lfsr u_lfsr (
    .clk(clk),
    .reset_n(reset_n),
    .run(run),
    .byte_out(gen_byte),
    .byte_done(gen_done)
  );

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    ctl_view = 8'h00;
    ctl_view[rsc_pkg::CTL_RSVD7_BIT] = rsc_pkg::RSVD7_VALUE;
    ctl_view[rsc_pkg::CTL_MASK_BIT] = st_q.mask;
    ctl_view[rsc_pkg::CTL_OVERLOAD_BIT] = ovl_sync;
    ctl_view[rsc_pkg::CTL_SUPPLY_EN_BIT] = st_q.supply_en;
    ctl_view[rsc_pkg::CTL_RSVD3_BIT] = rsc_pkg::RSVD3_VALUE;
    ctl_view[rsc_pkg::CTL_FORCE_BIT] = st_q.force_run;
    ctl_view[rsc_pkg::CTL_VALID_BIT] = st_q.valid;
    ctl_view[rsc_pkg::CTL_RSVD0_BIT] = rsc_pkg::RSVD0_VALUE;

    // register writes
    if (req.wr && req.addr == rsc_pkg::RANDOM_VALUE_ADDR) begin
      st_d.random_value = req.wdata;
    end
    if (req.wr && req.addr == rsc_pkg::RNG_SUPPLY_CONTROL_ADDR) begin
      st_d.mask = req.wdata[rsc_pkg::CTL_MASK_BIT];
      st_d.supply_en = req.wdata[rsc_pkg::CTL_SUPPLY_EN_BIT];
      st_d.force_run = req.wdata[rsc_pkg::CTL_FORCE_BIT];
      st_d.valid = req.wdata[rsc_pkg::CTL_VALID_BIT];
    end
    // read clears the flag; a new byte in the same cycle wins
    if (req.rd && req.addr == rsc_pkg::RANDOM_VALUE_ADDR) begin
      st_d.valid = 1'b0;
    end
    if (gen_done) begin
      st_d.random_value = gen_byte;
      st_d.valid = 1'b1;
    end

    // read data, one cycle after the strobe
    st_d.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        rsc_pkg::RANDOM_VALUE_ADDR: begin
          st_d.rdata = st_q.random_value;
        end
        rsc_pkg::RNG_SUPPLY_CONTROL_ADDR: begin
          st_d.rdata = ctl_view;
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end

    // secure pads and supply
    st_d.link_in = st_q.mask ? 1'b0 : link_sync;
    st_d.aux_pin = st_q.mask ? 1'b1 : aux_sync;
    st_d.sw_en = st_q.supply_en;
    st_d.tie_gnd = ~st_q.supply_en;

    // antenna drivers: coder alone, or coder mixed with link input
    st_d.drv1 = drive_bit;
    st_d.drv2 = drive_bit;

    // link clock source: oscillator for wired, field clock for virtual card
    st_d.clk_en = (link_clk_source_select == rsc_pkg::CLK_SRC_RF) ? rf_clk_en
                                                                  : osc_clk_en;
  end

  assign link_gated = st_q.mask ? 1'b0 : link_sync;
  assign drive_bit = driver_mix_select ? (coder_out | link_gated) : coder_out;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '{random_value: rsc_pkg::RANDOM_RESET, valid: 1'b0,
                force_run: rsc_pkg::FORCE_RESET, supply_en: rsc_pkg::SUPPLY_EN_RESET,
                mask: rsc_pkg::MASK_RESET, rdata: 8'h00, link_in: 1'b0, aux_pin: 1'b1,
                sw_en: 1'b0, tie_gnd: 1'b1, drv1: 1'b0, drv2: 1'b0, clk_en: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = st_q.rdata;
  assign secure_link_in_int = st_q.link_in;
  assign aux_secure_pin_int = st_q.aux_pin;
  assign supply_switch_en = st_q.sw_en;
  assign supply_tie_ground = st_q.tie_gnd;
  assign antenna_driver_1 = st_q.drv1;
  assign antenna_driver_2 = st_q.drv2;
  assign secure_link_clk_en = st_q.clk_en;
endmodule : rsc_top
`default_nettype wire

// [rsc_top_chk.sv]
// port checker for the random/supply block
`default_nettype none
module rsc_top_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic coder_out,
  input wire logic driver_mix_select,
  input wire logic link_clk_source_select,
  input wire logic rf_clk_en,
  input wire logic secure_link_in_int,
  input wire logic aux_secure_pin_int,
  input wire logic supply_switch_en,
  input wire logic supply_tie_ground,
  input wire logic antenna_driver_1,
  input wire logic antenna_driver_2,
  input wire logic secure_link_clk_en
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // input mask shadow and cycles since it was set
  logic ctl_wr;
  logic mask_q;
  logic [2:0] mcnt_q;
  assign ctl_wr = reg_wr && reg_addr == rsc_pkg::RNG_SUPPLY_CONTROL_ADDR;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_q <= rsc_pkg::MASK_RESET;
      mcnt_q <= 3'h7;
    end else begin
      mask_q <= ctl_wr ? reg_wdata[rsc_pkg::CTL_MASK_BIT] : mask_q;
      mcnt_q <= !mask_q ? 3'h0 : mcnt_q + {2'h0, mcnt_q != 3'h7};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_sup_wr(v); ctl_wr && reg_wdata[rsc_pkg::CTL_SUPPLY_EN_BIT] == v; endsequence
  sequence s_ctl_rd; reg_rd && reg_addr == rsc_pkg::RNG_SUPPLY_CONTROL_ADDR; endsequence
  property p_sup_on; s_sup_wr(1'b1) |=> ##1 supply_switch_en; endproperty
  a_sup_on: assert property (p_sup_on) else $error("supply not on");
  property p_sup_off; s_sup_wr(1'b0) |=> ##1 !supply_switch_en; endproperty
  a_sup_off: assert property (p_sup_off) else $error("supply not off");
  property p_tie; supply_tie_ground != supply_switch_en; endproperty
  a_tie: assert property (p_tie) else $error("ground tie wrong");
  property p_rsvd; s_ctl_rd |=> reg_rdata[0] && !reg_rdata[3] && !reg_rdata[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits wrong");
  property p_mask; mcnt_q == 3'h7 |-> !secure_link_in_int && aux_secure_pin_int; endproperty
  a_mask: assert property (p_mask) else $error("mask not applied");
  property p_plain; !driver_mix_select |=>
    {antenna_driver_1, antenna_driver_2} == {2{$past(coder_out)}}; endproperty
  a_plain: assert property (p_plain) else $error("driver not coder");
  property p_mix; driver_mix_select && coder_out |=> antenna_driver_1 && antenna_driver_2;
  endproperty
  a_mix: assert property (p_mix) else $error("mix lost coder");
  property p_rf; link_clk_source_select == rsc_pkg::CLK_SRC_RF |=>
    secure_link_clk_en == $past(rf_clk_en); endproperty
  a_rf: assert property (p_rf) else $error("field clock not selected");
endmodule : rsc_top_chk
bind rsc_top rsc_top_chk u_chk (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .coder_out, .driver_mix_select, .link_clk_source_select, .rf_clk_en,
  .secure_link_in_int, .aux_secure_pin_int, .supply_switch_en, .supply_tie_ground,
  .antenna_driver_1, .antenna_driver_2, .secure_link_clk_en);
`default_nettype wire

// [rsc_far_model.sv]
// far-side model: interface unit request, secure chip pads, coder stream
`default_nettype none
module rsc_far_model (
  input wire logic clk,
  input wire logic supply_switch_en,
  input wire logic [3:0] far_ctl,
  output logic ciu_rng_request,
  output logic secure_link_in_pad,
  output logic aux_secure_pin_pad,
  output logic overload_pad,
  output logic coder_out,
  output logic osc_clk_en,
  output logic rf_clk_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph = 2'h0;
  initial {ciu_rng_request, secure_link_in_pad, aux_secure_pin_pad, overload_pad} = 4'h0;
  initial {coder_out, osc_clk_en, rf_clk_en} = 3'h0;
  // ==========================================
  // far_ctl: generator wanted, link level, aux level, overload
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    coder_out <= ph[0];
    osc_clk_en <= !osc_clk_en;
    rf_clk_en <= ph == 2'h3;
    ciu_rng_request <= far_ctl[3];
    overload_pad <= supply_switch_en && far_ctl[0];
    // unpowered chip floats its pads: show a changing level
    secure_link_in_pad <= supply_switch_en ? far_ctl[2] : !secure_link_in_pad;
    aux_secure_pin_pad <= supply_switch_en ? far_ctl[1] : !aux_secure_pin_pad;
  end
endmodule : rsc_far_model
`default_nettype wire

// [testbench.sv]
// self-checking testbench for the random/supply block
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] CTL = rsc_pkg::RNG_SUPPLY_CONTROL_ADDR;
  localparam logic [15:0] RND = rsc_pkg::RANDOM_VALUE_ADDR;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic driver_mix_select = 1'b0, link_clk_source_select = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic [3:0] far_ctl = 4'h2;
  logic ciu_rng_request, secure_link_in_pad, aux_secure_pin_pad, overload_pad, coder_out;
  logic osc_clk_en, rf_clk_en, secure_link_in_int, aux_secure_pin_int, supply_switch_en;
  logic supply_tie_ground, antenna_driver_1, antenna_driver_2, secure_link_clk_en;
  int n_mismatch = 0, tests_run = 0;
  rsc_top u_dut (.*);
  rsc_far_model u_far (.*);
  initial forever #4 clk = ~clk;
  // ==========================================
  // register bus
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic poll(input int lim);
    d = 8'h00;
    for (int i = 0; i < lim && d[1] !== 1'b1; i++) rd(CTL);
  endtask : poll
  task automatic t_regs();
    rd(CTL);
    `CHK("ctl reset", 8'h41, d)
    @(posedge clk);
    #1;
    `CHK("rdata idle", 8'h00, reg_rdata)
    rd(16'h0000);
    `CHK("unmapped", 8'h00, d)
    wr(CTL, 8'he8);
    rd(CTL);
    `CHK("ctl reserved", 8'h41, d)
  endtask : t_regs
  task automatic t_rng();
    wr(RND, 8'h5a);
    repeat (30) @(posedge clk);
    rd(RND);
    `CHK("rnd idle", 8'h5a, d)
    @(posedge clk);
    far_ctl[3] <= 1'b1;
    poll(12);
    `CHK("ciu valid", 1'b1, d[1])
    @(posedge clk);
    far_ctl[3] <= 1'b0;
    repeat (12) @(posedge clk);
    rd(RND);
    rd(CTL);
    `CHK("read clear", 1'b0, d[1])
    wr(CTL, 8'h44);
    poll(8);
    `CHK("forced", 1'b1, d[1])
    wr(CTL, 8'h40);
    repeat (12) @(posedge clk);
    rd(RND);
  endtask : t_rng
  task automatic t_sup();
    wr(CTL, 8'h50);
    far_ctl <= 4'h5;
    repeat (10) @(posedge clk);
    #1;
    `CHK("on", 2'b10, {supply_switch_en, supply_tie_ground})
    rd(CTL);
    `CHK("overload", 8'h71, d)
    wr(CTL, 8'h10);
    far_ctl[0] <= 1'b0;
    driver_mix_select <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    `CHK("pass", 4'hb, {secure_link_in_int, aux_secure_pin_int, antenna_driver_1,
      antenna_driver_2})
    rd(CTL);
    `CHK("no overload", 8'h11, d)
    wr(CTL, 8'h50);
    driver_mix_select <= 1'b0;
    link_clk_source_select <= rsc_pkg::CLK_SRC_RF;
    repeat (10) @(posedge clk);
    #1;
    `CHK("masked", 2'b01, {secure_link_in_int, aux_secure_pin_int})
    wr(CTL, 8'h40);
    link_clk_source_select <= rsc_pkg::CLK_SRC_OSC;
    repeat (3) @(posedge clk);
    #1;
    `CHK("off", 2'b01, {supply_switch_en, supply_tie_ground})
    `CHK("osc clock", ~osc_clk_en, secure_link_clk_en)
  endtask : t_sup
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_rng();
    t_sup();
    summarize();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
